/* File: design/sfsw_defs.vh */
// Constants for the status-write and reset command interpreter of a serial flash.
// Assumes inclusion by the single design module; holds definitions only.
// How it works
// - First status write is refused unless the write enable latch is set.
// - Opcode 01h then one data byte; later bytes are ignored.
// - Byte one data: bit 7 lock value, bits 5..2 global code.
// - Valid byte-one write updates lock bit and clears latch at chip-select rise.
// - Global operation decided from bits 5..2 and the prior lock bit.
// - Short or misaligned byte-one write: lock kept, no global op, latch cleared.
// - With write protect asserted, clearing the lock ignores command, clears latch.
// - Second status write is refused unless the write enable latch is set.
// - Opcode 31h then one data byte; later bytes are ignored.
// - Byte two data: bit 4 reset enable, bit 3 lockdown enable.
// - Valid byte-two write updates enables, lockdown enable only if never frozen.
// - Short or misaligned byte-two write keeps enables but clears latch.
// - Reset command works regardless of the write enable latch.
// - Reset executes only when the reset enable bit is one.
// - Valid reset terminates program or erase in progress and returns idle.
// - Reset keeps lock and enables; clears latch and both suspend flags.
// - Reset during suspend aborts the suspended operation.
// - Reset needs opcode and confirmation complete and byte-aligned chip-select rise.
// - Lock bit set blocks sector protect commands and global operations.
// - Reset enable bit is zero after power-up.
`ifndef SFSW_DEFS_VH
`define SFSW_DEFS_VH
`define SFSW_OP_WRSR1      8'h01
`define SFSW_OP_WRSR2      8'h31
`define SFSW_OP_RESET      8'hF0
`define SFSW_RESET_CONFIRM 8'hD0
`define SFSW_B1_LOCK       7
`define SFSW_B1_GLOB_HI    5
`define SFSW_B1_GLOB_LO    2
`define SFSW_B2_RST_EN     4
`define SFSW_B2_LOCK_EN    3
`define SFSW_GLOB_PROTECT  4'hF
`define SFSW_GLOB_UNPROT   4'h0
`endif

/* File: design/sfsw_core.v */
// Status-register write and software reset command interpreter.
// Assumes SCK, CS_N and WP_N are pins sampled by REF_CLK_I, SPI modes 0 and 3.
`timescale 1ns/1ns
`include "sfsw_defs.vh"

module sfsw_core (
  input  wire       REF_CLK_I,
  input  wire       RESET_N_I,
  input  wire       SCK_I,
  input  wire       CS_N_I,
  input  wire       MOSI_I,
  input  wire       WP_N_I,
  input  wire       LATCH_SET_I,
  input  wire       FREEZE_I,
  input  wire       PROG_SUSP_I,
  input  wire       ERASE_SUSP_I,
  output reg        PROTECTION_LOCK_BIT_O,
  output reg        WRITE_ENABLE_LATCH_O,
  output reg        RESET_CMD_ENABLE_O,
  output reg        LOCKDOWN_CMD_ENABLE_O,
  output reg        PROGRAM_SUSPENDED_FLAG_O,
  output reg        ERASE_SUSPENDED_FLAG_O,
  output reg        GLOBAL_PROTECT_O,
  output reg        GLOBAL_UNPROTECT_O,
  output reg        SOFT_RESET_O
);

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers, plus a third stage for edge detection
  reg [2:0] sck_s;
  reg [2:0] cs_s;
  reg [1:0] mosi_s;
  reg [1:0] wp_s;

  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sck_s  <= 3'h0;
      cs_s   <= 3'h7;
      mosi_s <= 2'h0;
      wp_s   <= 2'h3;
    end else begin
      sck_s  <= {sck_s[1:0], SCK_I};
      cs_s   <= {cs_s[1:0], CS_N_I};
      mosi_s <= {mosi_s[0], MOSI_I};
      wp_s   <= {wp_s[0], WP_N_I};
    end
  end

  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire cs_rise  = cs_s[1] & ~cs_s[2];
  wire selected = ~cs_s[1];
  wire wp_on    = ~wp_s[1];

  ////////////////////////////////////////////////////////////////////////
  // Shift register and bit/byte counting
  reg [7:0] shift;
  reg [2:0] bit_cnt;
  reg [1:0] byte_cnt;
  reg [7:0] opcode;
  reg [7:0] data;
  wire [7:0] next_byte = {shift[6:0], mosi_s[1]};

  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      shift    <= 8'h00;
      bit_cnt  <= 3'h0;
      byte_cnt <= 2'h0;
      opcode   <= 8'h00;
      data     <= 8'h00;
    end else if (!selected) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 2'h0;
    end else if (sck_rise) begin
      shift   <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        // Only the first two bytes matter; later bytes are ignored
        if (byte_cnt == 2'h0)
          opcode <= next_byte;
        if (byte_cnt == 2'h1)
          data <= next_byte;
        if (byte_cnt != 2'h3)
          byte_cnt <= byte_cnt + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command evaluation at chip-select rise
  wire       aligned  = (bit_cnt == 3'h0);
  wire       have_op  = (byte_cnt != 2'h0);
  wire       complete = aligned && (byte_cnt >= 2'h2);
  wire       is_wr1   = have_op && (opcode == `SFSW_OP_WRSR1);
  wire       is_wr2   = have_op && (opcode == `SFSW_OP_WRSR2);
  wire       is_rst   = have_op && (opcode == `SFSW_OP_RESET);
  wire       new_lock = data[`SFSW_B1_LOCK];
  wire [3:0] glob     = data[`SFSW_B1_GLOB_HI:`SFSW_B1_GLOB_LO];
  reg        frozen;

  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PROTECTION_LOCK_BIT_O    <= 1'b0;
      WRITE_ENABLE_LATCH_O     <= 1'b0;
      RESET_CMD_ENABLE_O       <= 1'b0;
      LOCKDOWN_CMD_ENABLE_O    <= 1'b0;
      PROGRAM_SUSPENDED_FLAG_O <= 1'b0;
      ERASE_SUSPENDED_FLAG_O   <= 1'b0;
      GLOBAL_PROTECT_O         <= 1'b0;
      GLOBAL_UNPROTECT_O       <= 1'b0;
      SOFT_RESET_O             <= 1'b0;
      frozen                   <= 1'b0;
    end else begin
      GLOBAL_PROTECT_O   <= 1'b0;
      GLOBAL_UNPROTECT_O <= 1'b0;
      SOFT_RESET_O       <= 1'b0;
      if (FREEZE_I)
        frozen <= 1'b1;
      if (FREEZE_I || frozen)
        LOCKDOWN_CMD_ENABLE_O <= 1'b0;
      if (cs_rise && WRITE_ENABLE_LATCH_O && is_wr1) begin
        WRITE_ENABLE_LATCH_O <= 1'b0;
        if (complete && !(wp_on && !new_lock)) begin
          PROTECTION_LOCK_BIT_O <= new_lock;
          // Prior lock value gates the global operation
          if (!PROTECTION_LOCK_BIT_O) begin
            GLOBAL_PROTECT_O   <= (glob == `SFSW_GLOB_PROTECT);
            GLOBAL_UNPROTECT_O <= (glob == `SFSW_GLOB_UNPROT);
          end
        end
      end
      if (cs_rise && WRITE_ENABLE_LATCH_O && is_wr2) begin
        WRITE_ENABLE_LATCH_O <= 1'b0;
        if (complete) begin
          RESET_CMD_ENABLE_O <= data[`SFSW_B2_RST_EN];
          if (!frozen && !FREEZE_I)
            LOCKDOWN_CMD_ENABLE_O <= data[`SFSW_B2_LOCK_EN];
        end
      end
      // Latch state not checked for reset
      if (cs_rise && is_rst && complete && RESET_CMD_ENABLE_O
          && data == `SFSW_RESET_CONFIRM) begin
        SOFT_RESET_O             <= 1'b1;
        WRITE_ENABLE_LATCH_O     <= 1'b0;
        PROGRAM_SUSPENDED_FLAG_O <= 1'b0;
        ERASE_SUSPENDED_FLAG_O   <= 1'b0;
      end
      // Sets come last so a set in the same cycle as a clear wins
      if (PROG_SUSP_I)
        PROGRAM_SUSPENDED_FLAG_O <= 1'b1;
      if (ERASE_SUSP_I)
        ERASE_SUSPENDED_FLAG_O <= 1'b1;
      if (LATCH_SET_I)
        WRITE_ENABLE_LATCH_O <= 1'b1;
    end
  end

endmodule

/* File: verification/sfsw_host.sv */
// Serial host model driving chip select, clock and data in mode 0.
// Assumes the core clock paces it; clock stands still between frames.
`timescale 1ns/1ns
module sfsw_host (
  input  wire  clk,
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sck = 0;
    cs_n = 1;
    mosi = 0;
  end
  // Sends n bits MSB first, then releases the data line inverted
  task frame(input logic [23:0] d, input int n);
    @(negedge clk) cs_n = 0;
    for (int i = 0; i < n; i++) begin
      mosi = d[23-i];
      repeat (4) @(negedge clk);
      sck = 1;
      repeat (4) @(negedge clk);
      sck = 0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1;
    mosi = ~mosi;
    repeat (12) @(negedge clk);
  endtask
endmodule

/* File: verification/sfsw_core_sva.sv */
// Port checker for the status-write and reset interpreter.
// Assumes outputs settle 3 to 4 core cycles after chip select rises.
`timescale 1ns/1ns
module sfsw_core_sva (
  input wire REF_CLK_I,
  input wire RESET_N_I,
  input wire CS_N_I,
  input wire WP_N_I,
  input wire FREEZE_I,
  input wire PROTECTION_LOCK_BIT_O,
  input wire WRITE_ENABLE_LATCH_O,
  input wire RESET_CMD_ENABLE_O,
  input wire LOCKDOWN_CMD_ENABLE_O,
  input wire PROGRAM_SUSPENDED_FLAG_O,
  input wire ERASE_SUSPENDED_FLAG_O,
  input wire GLOBAL_PROTECT_O,
  input wire GLOBAL_UNPROTECT_O,
  input wire SOFT_RESET_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_lock_at_end: assert property ($changed(PROTECTION_LOCK_BIT_O) |-> $past(CS_N_I, 2))
    else $error("lock moved while selected");
  a_wp_no_clear: assert property ($fell(PROTECTION_LOCK_BIT_O) |-> $past(WP_N_I, 2))
    else $error("lock cleared under write protect");
  a_glob_unlocked: assert property ((GLOBAL_PROTECT_O || GLOBAL_UNPROTECT_O)
    |-> !$past(PROTECTION_LOCK_BIT_O, 2)) else $error("global op while locked");
  a_rst_en_at_end: assert property ($changed(RESET_CMD_ENABLE_O) |-> $past(CS_N_I, 2))
    else $error("reset enable moved while selected");
  a_frozen_sle: assert property (FREEZE_I |-> ##[1:4] !LOCKDOWN_CMD_ENABLE_O)
    else $error("lockdown enable not frozen");
  a_reset_enabled: assert property (SOFT_RESET_O |-> RESET_CMD_ENABLE_O)
    else $error("reset while disabled");
  a_reset_clears: assert property (SOFT_RESET_O |=> !WRITE_ENABLE_LATCH_O
    && !PROGRAM_SUSPENDED_FLAG_O && !ERASE_SUSPENDED_FLAG_O) else $error("reset left flags");
  a_reset_keeps: assert property (SOFT_RESET_O |=> $stable(PROTECTION_LOCK_BIT_O)
    && $stable(RESET_CMD_ENABLE_O)) else $error("reset changed kept bits");
  a_reset_single: assert property (SOFT_RESET_O |=> !SOFT_RESET_O)
    else $error("reset pulse too long");
  c_gprot: cover property (GLOBAL_PROTECT_O);
  c_gunprot: cover property (GLOBAL_UNPROTECT_O);
  c_reset: cover property (SOFT_RESET_O);
endmodule
bind sfsw_core sfsw_core_sva chk (.*);

/* File: verification/sfsw_core_bench.sv */
// Testbench for the status-write and reset interpreter.
// Assumes the host model drives the serial pins and the checker is bound.
`timescale 1ns/1ns
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", n, e, v); end end
module sfsw_core_bench;
  logic REF_CLK_I = 0, RESET_N_I = 0, WP_N_I = 1, LATCH_SET_I = 0, FREEZE_I = 0;
  logic PROG_SUSP_I = 0, ERASE_SUSP_I = 0;
  wire  SCK_I, CS_N_I, MOSI_I, PROTECTION_LOCK_BIT_O, WRITE_ENABLE_LATCH_O;
  wire  RESET_CMD_ENABLE_O, LOCKDOWN_CMD_ENABLE_O, PROGRAM_SUSPENDED_FLAG_O;
  wire  ERASE_SUSPENDED_FLAG_O, GLOBAL_PROTECT_O, GLOBAL_UNPROTECT_O, SOFT_RESET_O;
  int   errors = 0, checks = 0, ngp = 0, ngu = 0, nsr = 0;
  always #25 REF_CLK_I = ~REF_CLK_I;
  sfsw_core DUT (.*);
  sfsw_host host (.clk(REF_CLK_I), .sck(SCK_I), .cs_n(CS_N_I), .mosi(MOSI_I));
  // Tallies one-cycle pulses
  always @(posedge REF_CLK_I) begin
    ngp += (GLOBAL_PROTECT_O === 1'b1);
    ngu += (GLOBAL_UNPROTECT_O === 1'b1);
    nsr += (SOFT_RESET_O === 1'b1);
  end
  // Optional write enable, then one frame
  task cmd(input logic w, input logic [23:0] d, input int n);
    if (w) begin
      @(negedge REF_CLK_I) LATCH_SET_I = 1;
      @(negedge REF_CLK_I) LATCH_SET_I = 0;
    end
    host.frame(d, n);
  endtask
  // Compares lock, latch and the two enable outputs, and the pulse tallies
  task ex(input string t, input logic l, w, r, s, input int p, u, x);
    `CHK("lock", l, PROTECTION_LOCK_BIT_O)
    `CHK("latch", w, WRITE_ENABLE_LATCH_O)
    `CHK("rst_en", r, RESET_CMD_ENABLE_O)
    `CHK("lock_en", s, LOCKDOWN_CMD_ENABLE_O)
    `CHK("gprot", p, ngp)
    `CHK("gunprot", u, ngu)
    `CHK("softrst", x, nsr)
    $display("test %s done", t);
  endtask
  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    results;
  end
  initial begin
    repeat (8) @(negedge REF_CLK_I);
    RESET_N_I = 1;
    repeat (3) @(negedge REF_CLK_I);
    ex("power", 0, 0, 0, 0, 0, 0, 0);
    cmd(0, 24'h018000, 16);
    ex("nowel", 0, 0, 0, 0, 0, 0, 0);
    cmd(0, 24'hF0D000, 16);
    ex("rstoff", 0, 0, 0, 0, 0, 0, 0);
    cmd(1, 24'h0180FF, 24);
    ex("lock", 1, 0, 0, 0, 0, 1, 0);
    WP_N_I = 0;
    cmd(1, 24'h017F00, 16);
    ex("wp", 1, 0, 0, 0, 0, 1, 0);
    WP_N_I = 1;
    cmd(1, 24'h017F00, 16);
    ex("unlock", 0, 0, 0, 0, 0, 1, 0);
    cmd(1, 24'h017F00, 16);
    ex("gprot", 0, 0, 0, 0, 1, 1, 0);
    cmd(1, 24'h018000, 12);
    ex("short1", 0, 0, 0, 0, 1, 1, 0);
    cmd(1, 24'h31F800, 16);
    ex("wr2", 0, 0, 1, 1, 1, 1, 0);
    cmd(1, 24'h310000, 15);
    ex("short2", 0, 0, 1, 1, 1, 1, 0);
    cmd(0, 24'h310000, 16);
    ex("nowel2", 0, 0, 1, 1, 1, 1, 0);
    @(negedge REF_CLK_I) FREEZE_I = 1;
    @(negedge REF_CLK_I) FREEZE_I = 0;
    cmd(1, 24'h311800, 16);
    ex("frozen", 0, 0, 1, 0, 1, 1, 0);
    cmd(0, 24'hF0D000, 12);
    cmd(0, 24'hF00000, 8);
    ex("rstshort", 0, 0, 1, 0, 1, 1, 0);
    @(negedge REF_CLK_I) {PROG_SUSP_I, ERASE_SUSP_I} = 2'b11;
    @(negedge REF_CLK_I) {PROG_SUSP_I, ERASE_SUSP_I} = 2'b00;
    `CHK("susp_set", 2'b11, {PROGRAM_SUSPENDED_FLAG_O, ERASE_SUSPENDED_FLAG_O})
    cmd(1, 24'hF0D055, 24);
    ex("rst", 0, 0, 1, 0, 1, 1, 1);
    `CHK("susp", 2'b00, {PROGRAM_SUSPENDED_FLAG_O, ERASE_SUSPENDED_FLAG_O})
    cmd(0, 24'hF0D000, 16);
    ex("rstnowel", 0, 0, 1, 0, 1, 1, 2);
    results;
  end
endmodule
